// ### shared/pmm_pkg.sv
// Package for the program memory mode map block.
// Assumes a 16-bit program address space and 16-bit register data.
package pmm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PMM_OFS_BUS_WAIT = 16'hFFF9;
  localparam logic [15:0] PMM_OFS_OP_MODE = 16'hFFFB;
  localparam logic [15:0] PMM_OFS_STATUS = 16'hFFFC;

  // Operating mode register fields
  localparam int PMM_POS_MODE_LOW = 0;
  localparam int PMM_POS_MODE_HIGH = 1;
  localparam int PMM_POS_BOOT_SUB = 2;

  // Bus wait control fields: four wait bits, low two hardwired
  localparam int PMM_POS_WAIT_LSB = 0;
  localparam int PMM_POS_WAIT_PROG = 2;
  localparam logic [15:0] PMM_BUS_WAIT_RESET = 16'h0000;
  localparam logic [15:0] PMM_BUS_WAIT_MASK = 16'h000C;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] PMM_HW_RESET_VEC = 16'h0000;
  localparam logic [15:0] PMM_WD_RESET_VEC = 16'h0002;
  localparam logic [15:0] PMM_ALIAS_LAST = 16'h0003;
  localparam logic [15:0] PMM_BOOT_BASE = 16'h8000;
  localparam logic [15:0] PMM_BOOT_LAST = 16'h87FF;
  localparam logic [15:0] PMM_HALF_BASE = 16'h8000;
  localparam logic [15:0] PMM_PFLASH_SIZE = 16'h7E00;
  localparam logic [15:0] PMM_PROGRAM_RAM_SIZE = 16'h0200;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMM_MODE_SINGLE = 2'b00,
    PMM_MODE_EXTERNAL = 2'b11
  } pmm_mode_t;

  typedef struct packed {
    logic prog_flash;
    logic prog_ram;
    logic boot_flash;
    logic ext_bus;
  } pmm_sel_t;

  typedef struct packed {
    pmm_sel_t sel;
    logic [15:0] addr;
  } pmm_route_t;

endpackage : pmm_pkg

// ### src/pmm_mode_latch.sv
// Holds the operating mode bits and their boot-pin shadow.
// Assumes the boot pin is synchronous to the core clock.
`timescale 1ns/1ps
module pmm_mode_latch (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_boot_select_pin,
  input wire logic i_watchdog_reset,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_wdata,
  output pmm_pkg::pmm_mode_t o_mode,
  output pmm_pkg::pmm_mode_t o_latched_mode
);
  import pmm_pkg::*;

  pmm_mode_t mode_reg;
  pmm_mode_t latched_reg;
  pmm_mode_t strap_mode;
  logic first_reg;

  // Strap level decodes to a valid mode only
  assign strap_mode = i_boot_select_pin ? PMM_MODE_EXTERNAL : PMM_MODE_SINGLE;

  // ----------------------------------------------------------------
  // Boot strap capture
  // ----------------------------------------------------------------
  // Reset loads constants only; the pin is caught on the first edge after release
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_reg <= 1'b1;
      latched_reg <= PMM_MODE_SINGLE;
    end else if (i_clk_en && first_reg) begin
      first_reg <= 1'b0;
      latched_reg <= i_boot_select_pin ? PMM_MODE_EXTERNAL : PMM_MODE_SINGLE;
    end
  end

  // ----------------------------------------------------------------
  // Live mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg <= PMM_MODE_SINGLE;
    end else if (i_clk_en) begin
      if (first_reg) begin
        mode_reg <= i_boot_select_pin ? PMM_MODE_EXTERNAL : PMM_MODE_SINGLE;
      end else if (i_watchdog_reset) begin
        mode_reg <= latched_reg;
      end else if (i_mode_wr) begin
        // Mixed codes are dropped so the map never goes undefined
        unique case (i_mode_wdata)
          2'b00: mode_reg <= PMM_MODE_SINGLE;
          2'b11: mode_reg <= PMM_MODE_EXTERNAL;
          default: mode_reg <= mode_reg;
        endcase
      end
    end
  end

  // First cycle after release already shows the strap, so an early fetch decodes right
  assign o_mode = first_reg ? strap_mode : mode_reg;
  assign o_latched_mode = first_reg ? strap_mode : latched_reg;

endmodule : pmm_mode_latch

// ### src/pmm_addr_decode.sv
// Combinational program address decoder.
// Assumes the mode input is already a valid encoding.
`timescale 1ns/1ps
module pmm_addr_decode #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input pmm_pkg::pmm_mode_t i_mode,
  input wire logic i_boot_sub,
  input wire logic [15:0] i_addr,
  output pmm_pkg::pmm_route_t o_route
);
  import pmm_pkg::*;

  function automatic pmm_route_t route_one(input logic [15:0] a);
    pmm_route_t r;
    r = '0;
    r.addr = a;
    if (a <= PMM_ALIAS_LAST) begin
      r.sel.boot_flash = 1'b1;
      r.addr = PMM_BOOT_BASE | a;
    end else if (a >= PMM_BOOT_BASE && a <= PMM_BOOT_LAST) begin
      r.sel.boot_flash = 1'b1;
    end else if (a < PMM_PFLASH_SIZE) begin
      r.sel.prog_flash = 1'b1;
    end else if (a < PMM_PFLASH_SIZE + PMM_PROGRAM_RAM_SIZE) begin
      r.sel.prog_ram = 1'b1;
    end else if (!i_boot_sub && HAS_EXT_BUS && a >= PMM_HALF_BASE) begin
      r.sel.ext_bus = 1'b1;
    end else begin
      // Unpopulated internal space falls back to program flash, never data RAM
      r.sel.prog_flash = 1'b1;
    end
    return r;
  endfunction : route_one

  always_comb begin
    o_route = '0;
    o_route.addr = i_addr;
    unique case (i_mode)
      PMM_MODE_EXTERNAL: begin
        // Without an external interface there is nowhere else to go
        if (HAS_EXT_BUS) begin
          o_route.sel.ext_bus = 1'b1;
        end else begin
          o_route = route_one(i_addr);
        end
      end
      PMM_MODE_SINGLE: o_route = route_one(i_addr);
      default: o_route = route_one(i_addr);
    endcase
  end

endmodule : pmm_addr_decode

// ### src/pmm_mode_map.sv
// Top of the program memory mode map: registers, mode state and decoder.
// Assumes a single core clock and a plain strobe register port.
//
// What this block does
// - Boot pin sampled leaving reset sets mode
// - Only codes 00 and 11 are valid
// - Mode write remaps memory without reset
// - Watchdog reset restores latched boot mode
// - Reset vectors at 0000 and 0002
// - Addresses zero to three alias boot flash
// - Vectors map to boot 8000 and 8002
// - Mode 3 routes all space external
// - Boot sub-mode internal, else upper external
// - Low boot pin enters boot sub-mode
// - Expansion only when external bus exists
// - Two wait bits set external access time
// - Low two wait bits read zero
// - Fetches never go to data RAM
`timescale 1ns/1ps
module pmm_mode_map #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_boot_select_pin,
  input wire logic i_watchdog_reset,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  output pmm_pkg::pmm_route_t o_fetch_route,
  output logic o_fetch_valid,
  output logic [15:0] o_hw_reset_vec,
  output logic [15:0] o_wd_reset_vec,
  output logic o_vec_external,
  output logic [1:0] o_ext_wait_states
);
  import pmm_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  pmm_mode_t mode;
  pmm_mode_t latched_mode;
  pmm_route_t route_next;
  logic [15:0] bus_wait_reg;
  logic boot_sub_reg;
  logic boot_sub_first_reg;
  logic mode_wr;
  logic wait_wr;

  assign mode_wr = i_reg_wr && (i_reg_addr == PMM_OFS_OP_MODE);
  assign wait_wr = i_reg_wr && (i_reg_addr == PMM_OFS_BUS_WAIT);

  pmm_mode_latch u_latch (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_boot_select_pin(i_boot_select_pin),
    .i_watchdog_reset(i_watchdog_reset),
    .i_mode_wr(mode_wr),
    .i_mode_wdata({i_reg_wdata[PMM_POS_MODE_HIGH], i_reg_wdata[PMM_POS_MODE_LOW]}),
    .o_mode(mode),
    .o_latched_mode(latched_mode)
  );

  // ----------------------------------------------------------------
  // Single-chip sub-mode
  // ----------------------------------------------------------------
  // Boot sub-mode is forced at start-up; with HAS_EXT_BUS set, software leaves it by writing the bit clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_sub_reg <= 1'b1;
      boot_sub_first_reg <= 1'b1;
    end else if (i_clk_en) begin
      boot_sub_first_reg <= 1'b0;
      if (boot_sub_first_reg || i_watchdog_reset) begin
        boot_sub_reg <= 1'b1;
      end else if (mode_wr) begin
        boot_sub_reg <= i_reg_wdata[PMM_POS_BOOT_SUB] || !HAS_EXT_BUS;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus wait control
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_wait_reg <= PMM_BUS_WAIT_RESET;
    end else if (i_clk_en && wait_wr) begin
      bus_wait_reg <= i_reg_wdata & PMM_BUS_WAIT_MASK;
    end
  end

  assign o_ext_wait_states = bus_wait_reg[PMM_POS_WAIT_PROG +: 2];

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_clk_en) begin
      o_reg_rdata <= 16'h0000;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          PMM_OFS_BUS_WAIT: o_reg_rdata <= bus_wait_reg;
          PMM_OFS_OP_MODE: begin
            o_reg_rdata[PMM_POS_MODE_LOW] <= mode[0];
            o_reg_rdata[PMM_POS_MODE_HIGH] <= mode[1];
            o_reg_rdata[PMM_POS_BOOT_SUB] <= boot_sub_reg;
          end
          PMM_OFS_STATUS: begin
            o_reg_rdata[PMM_POS_MODE_LOW] <= latched_mode[0];
            o_reg_rdata[PMM_POS_MODE_HIGH] <= latched_mode[1];
          end
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Fetch routing
  // ----------------------------------------------------------------
  pmm_addr_decode #(
    .HAS_EXT_BUS(HAS_EXT_BUS)
  ) u_decode (
    .i_mode(mode),
    .i_boot_sub(boot_sub_reg),
    .i_addr(i_fetch_addr),
    .o_route(route_next)
  );

  // One register stage gives the remap its one-instruction settling slot
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fetch_route <= '0;
      o_fetch_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_fetch_valid <= i_fetch_req;
      if (i_fetch_req) begin
        o_fetch_route <= route_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset vectors
  // ----------------------------------------------------------------
  // Watchdog vector placement follows the strap, not the live bits
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hw_reset_vec <= PMM_BOOT_BASE | PMM_HW_RESET_VEC;
      o_wd_reset_vec <= PMM_BOOT_BASE | PMM_WD_RESET_VEC;
      o_vec_external <= 1'b0;
    end else if (i_clk_en) begin
      if (latched_mode == PMM_MODE_EXTERNAL && HAS_EXT_BUS) begin
        o_hw_reset_vec <= PMM_HW_RESET_VEC;
        o_wd_reset_vec <= PMM_WD_RESET_VEC;
        o_vec_external <= 1'b1;
      end else begin
        o_hw_reset_vec <= PMM_BOOT_BASE | PMM_HW_RESET_VEC;
        o_wd_reset_vec <= PMM_BOOT_BASE | PMM_WD_RESET_VEC;
        o_vec_external <= 1'b0;
      end
    end
  end

endmodule : pmm_mode_map

// ### tb/pmm_mode_map_sva.sv
// Checker for the program memory mode map top.
// Assumes one clock domain; every request is qualified by the clock enable.
`timescale 1ns/1ps
module pmm_mode_map_sva import pmm_pkg::*; #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_watchdog_reset,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  input pmm_pkg::pmm_route_t o_fetch_route,
  input wire logic o_fetch_valid,
  input wire logic [15:0] o_hw_reset_vec,
  input wire logic [15:0] o_wd_reset_vec,
  input wire logic o_vec_external,
  input wire logic [1:0] o_ext_wait_states
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence wd_pulse_s;
    i_watchdog_reset && i_clk_en;
  endsequence
  sequence fetch_wd_vec_s;
    i_fetch_req && i_clk_en && i_fetch_addr == PMM_WD_RESET_VEC;
  endsequence
  // A legal mode write between pulse and fetch would change the map on purpose
  sequence no_mode_wr_s;
    !(i_reg_wr && i_reg_addr == PMM_OFS_OP_MODE);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rd_wait_a: assert property (i_reg_rd && i_clk_en && i_reg_addr == PMM_OFS_BUS_WAIT
    |=> (o_reg_rdata & ~PMM_BUS_WAIT_MASK) == 16'h0000 && o_reg_rdata[3:2] == o_ext_wait_states)
    else $error("bus wait read shows fixed bits set");
  wait_bits_a: assert property (i_reg_wr && i_clk_en && i_reg_addr == PMM_OFS_BUS_WAIT
    |=> o_ext_wait_states == $past(i_reg_wdata[3:2])) else $error("wait states not loaded");
  fetch_valid_a: assert property (i_fetch_req && i_clk_en |=> o_fetch_valid)
    else $error("fetch not answered next cycle");
  sel_onehot_a: assert property (o_fetch_valid |-> $onehot(o_fetch_route.sel))
    else $error("fetch select not one-hot");
  vec_ext_a: assert property (o_vec_external
    |-> o_hw_reset_vec == 16'h0000 && o_wd_reset_vec == 16'h0002) else $error("external vectors");
  vec_int_a: assert property (!o_vec_external
    |-> o_hw_reset_vec == 16'h8000 && o_wd_reset_vec == 16'h8002) else $error("boot vectors");
  alias_boot_a: assert property (i_fetch_req && i_clk_en && i_fetch_addr <= 16'h0003
    |=> o_fetch_route.sel.ext_bus || (o_fetch_route.sel.boot_flash
    && o_fetch_route.addr == (PMM_BOOT_BASE | $past(i_fetch_addr)))) else $error("alias miss");
  wd_remap_a: assert property (wd_pulse_s ##1 no_mode_wr_s ##1 fetch_wd_vec_s
    |=> o_fetch_route.sel.ext_bus == o_vec_external) else $error("watchdog mode not restored");
endmodule : pmm_mode_map_sva

bind pmm_mode_map pmm_mode_map_sva #(.HAS_EXT_BUS(HAS_EXT_BUS)) u_pmm_mode_map_sva (.*);

// ### tb/pmm_ext_prog_mem.sv
// Behavioural external program memory on the expansion bus.
// Assumes routed fetches arrive as the registered route of the top.
`timescale 1ns/1ps
module pmm_ext_prog_mem import pmm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_fetch_valid,
  input pmm_pkg::pmm_route_t i_route,
  output logic [15:0] o_ext_word
);
  logic [15:0] idle_reg = 16'h0000;
  // Unselected bus keeps changing so a stale word never looks valid
  always_ff @(posedge i_sys_clk) begin
    idle_reg <= ~idle_reg;
  end
  assign o_ext_word = (i_fetch_valid && i_route.sel.ext_bus) ? (i_route.addr ^ 16'hA5A5)
    : idle_reg;
endmodule : pmm_ext_prog_mem

// ### tb/pmm_mode_map_test.sv
// Self-checking bench for the program memory mode map.
// Assumes the checker is bound in and the external memory model answers fetches.
`timescale 1ns/1ps
module pmm_mode_map_test import pmm_pkg::*; ;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, strap = 1'b0, wd = 1'b0, wr = 1'b0, rd = 1'b0;
  logic req = 1'b0, en = 1'b1;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, faddr = 16'h0000, rdata, hw_vec, wd_vec;
  logic [15:0] ext_word;
  logic vec_ext, fvalid;
  logic [1:0] wait_st;
  pmm_route_t route;
  int mismatches = 0, checks_done = 0, cycles = 0;
  pmm_mode_map u_pmm_mode_map (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(en),
    .i_boot_select_pin(strap), .i_watchdog_reset(wd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_fetch_req(req),
    .i_fetch_addr(faddr), .o_fetch_route(route), .o_fetch_valid(fvalid),
    .o_hw_reset_vec(hw_vec), .o_wd_reset_vec(wd_vec), .o_vec_external(vec_ext),
    .o_ext_wait_states(wait_st));
  pmm_ext_prog_mem u_pmm_ext_prog_mem (.i_sys_clk(i_sys_clk), .i_fetch_valid(fvalid),
    .i_route(route), .o_ext_word(ext_word));
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic s);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    strap <= s;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
  endtask : do_reset
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1 chk({4'h0, rdata}, {4'h0, e});
  endtask : reg_rd
  task automatic fetch(input logic [15:0] a, input logic [3:0] s, input logic [15:0] ea);
    @(posedge i_sys_clk);
    req <= 1'b1;
    faddr <= a;
    @(posedge i_sys_clk);
    req <= 1'b0;
    #1 chk(route, {s, ea});
    if (s == 4'h1) chk({4'h0, ext_word}, {4'h0, ea ^ 16'hA5A5});
  endtask : fetch
  task automatic wd_pulse;
    @(posedge i_sys_clk);
    wd <= 1'b1;
    @(posedge i_sys_clk);
    wd <= 1'b0;
  endtask : wd_pulse
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  // No interrupt source here, and every write task leaves an idle cycle behind it
  initial begin
    do_reset(1'b0);
    reg_rd(PMM_OFS_OP_MODE, 16'h0004);
    reg_rd(PMM_OFS_STATUS, 16'h0000);
    fetch(16'h0002, 4'h2, 16'h8002);
    fetch(16'h0003, 4'h2, 16'h8003);
    fetch(16'h1000, 4'h8, 16'h1000);
    fetch(16'h7E00, 4'h4, 16'h7E00);
    fetch(16'h9000, 4'h8, 16'h9000);
    chk({3'h0, vec_ext, hw_vec}, {4'h0, 16'h8000});
    $display("test boot strap low done");
    reg_wr(PMM_OFS_OP_MODE, 16'h0000);
    fetch(16'h9000, 4'h1, 16'h9000);
    reg_wr(PMM_OFS_OP_MODE, 16'h0001);
    reg_rd(PMM_OFS_OP_MODE, 16'h0000);
    reg_wr(PMM_OFS_OP_MODE, 16'h0002);
    reg_rd(PMM_OFS_OP_MODE, 16'h0000);
    fetch(16'h1000, 4'h8, 16'h1000);
    reg_wr(PMM_OFS_OP_MODE, 16'h0003);
    fetch(16'h1000, 4'h1, 16'h1000);
    chk({4'h0, hw_vec}, {4'h0, 16'h8000});
    wd_pulse();
    fetch(16'h0002, 4'h2, 16'h8002);
    reg_rd(PMM_OFS_OP_MODE, 16'h0004);
    $display("test mode change done");
    reg_rd(PMM_OFS_BUS_WAIT, 16'h0000);
    reg_wr(PMM_OFS_BUS_WAIT, 16'hFFFF);
    reg_rd(PMM_OFS_BUS_WAIT, 16'h000C);
    chk({18'h0_0000, wait_st}, 20'h0_0003);
    reg_rd(16'hFFF0, 16'h0000);
    // A write while the clock enable is low must leave the wait bits alone
    @(posedge i_sys_clk);
    en <= 1'b0;
    reg_wr(PMM_OFS_BUS_WAIT, 16'h0000);
    en <= 1'b1;
    reg_rd(PMM_OFS_BUS_WAIT, 16'h000C);
    chk({18'h0_0000, wait_st}, 20'h0_0003);
    $display("test bus wait done");
    do_reset(1'b1);
    reg_rd(PMM_OFS_OP_MODE, 16'h0007);
    reg_rd(PMM_OFS_STATUS, 16'h0003);
    fetch(16'h0000, 4'h1, 16'h0000);
    chk({3'h0, vec_ext, wd_vec}, {4'h1, 16'h0002});
    reg_wr(PMM_OFS_OP_MODE, 16'h0004);
    fetch(16'h0002, 4'h2, 16'h8002);
    wd_pulse();
    fetch(16'h0002, 4'h1, 16'h0002);
    $display("test strap high done");
    print_verdict();
  end
endmodule : pmm_mode_map_test
